// >>> logic/fea_pkg.sv
// How it works
// - Status bits 15:8 read back the number of FIFO bytes now waiting to be read.
// - The fill count is in bytes and the threshold in two-byte words, so bytes are halved before comparing.
// - With FIFO access enabled, a one written to status bit 15 sends a one-cycle FIFO clear pulse.
// - The slot B event flag sets on its event, holds, clears on a written one and ignores a written zero.
// - The slot A event flag sets on its event, holds, clears on a written one and ignores a written zero.
// - Reserved status bit 7 clears to zero when a one is written to it.
// - Reserved status bits 4:0 clear to zero only when all ones are written to them.
// - The FIFO level event reaches the alert only while its mask bit is zero.
// - The slot B event is kept off the alert while its mask bit is one, its reset value.
// - The slot A event is kept off the alert while its mask bit is one, its reset value.
// - With the pin enable bit clear the alert pin floats, while the flags keep updating.
// - Drive style zero drives the pin whenever the pin is enabled; one drives it only while asserted, open-drain fashion.
// - Polarity zero makes the pin active high, one makes it active low.
// - The FIFO level event is raised while the stored word count is strictly above the six-bit threshold.
// - The FIFO level event drops by itself once the word count no longer exceeds the threshold.
package fea_pkg;

    // ************************************************************
    // Register bus widths and offsets
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam logic [7:0]  ADDR_STATUS = 8'h00;
    localparam logic [7:0]  ADDR_MASK   = 8'h01;
    localparam logic [7:0]  ADDR_CFG    = 8'h02;
    localparam logic [7:0]  ADDR_THRESH = 8'h06;
    localparam logic [7:0]  ADDR_IDENT  = 8'h08;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned STAT_CLR_BIT  = 15;
    localparam int unsigned STAT_RSV7_BIT = 7;
    localparam int unsigned STAT_B_BIT    = 6;
    localparam int unsigned STAT_A_BIT    = 5;
    localparam logic [4:0]  STAT_RSV_ALL  = 5'h1f;
    localparam int unsigned STAT_RSV_W    = 5;
    localparam int unsigned MASK_W        = 9;
    localparam logic [8:0]  MASK_RESET    = 9'h0ff;
    localparam int unsigned MASK_FIFO_BIT = 8;
    localparam int unsigned MASK_B_BIT    = 6;
    localparam int unsigned MASK_A_BIT    = 5;
    localparam int unsigned CFG_EN_BIT    = 2;
    localparam int unsigned CFG_DRV_BIT   = 1;
    localparam int unsigned CFG_POL_BIT   = 0;
    localparam int unsigned CFG_W         = 3;
    localparam logic [2:0]  CFG_RESET     = 3'h0;
    localparam int unsigned THR_W         = 6;
    localparam int unsigned THR_LSB       = 8;
    localparam logic [5:0]  THR_RESET     = 6'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } fea_req_t;

    typedef struct packed {
        logic slot_b;
        logic slot_a;
    } fea_evt_t;

    // Write strobe aimed at one register
    function automatic logic fea_wr_hit(input fea_req_t req, input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction : fea_wr_hit

    // Byte count turned into two-byte words
    function automatic logic [6:0] fea_words(input logic [7:0] bytes);
        return bytes[7:1];
    endfunction : fea_words

endpackage : fea_pkg

// >>> logic/fea_flag.sv
`timescale 1ns/1ns
`default_nettype none
module fea_flag (
    input  wire logic ref_clk_in,   // Block clock
    input  wire logic nrst_in,      // Async reset, active low
    input  wire logic set_in,       // Event pulse
    input  wire logic clr_in,       // Write-one-to-clear strobe
    output var  logic flag_out      // Sticky flag
);

    logic flag_r;
    logic flag_nxt;

    // Set wins over a clear in the same cycle
    always_comb begin
        flag_nxt = set_in | (flag_r & ~clr_in);
    end

    // Flag register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_out = flag_r;

endmodule : fea_flag
`default_nettype wire

// >>> logic/fea_pin.sv
`timescale 1ns/1ns
`default_nettype none
module fea_pin (
    input  wire logic ref_clk_in,   // Block clock
    input  wire logic nrst_in,      // Async reset, active low
    input  wire logic asserted_in,  // Alert condition
    input  wire logic enable_in,    // Pin enable
    input  wire logic drive_in,     // Drive style, 1 open drain
    input  wire logic polarity_in,  // 1 active low
    output var  logic pin_out,      // Pin level
    output var  logic pin_oe_out    // Pin driven
);

    logic pin_r;
    logic oe_r;
    logic pin_nxt;
    logic oe_nxt;

    // Pin level and enable from the settings
    always_comb begin
        pin_nxt = asserted_in ^ polarity_in;
        oe_nxt  = enable_in & (~drive_in | asserted_in);
    end

    // Pin registers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign pin_out    = pin_r;
    assign pin_oe_out = oe_r;

endmodule : fea_pin
`default_nettype wire

// >>> logic/fea_top.sv
`timescale 1ns/1ns
`default_nettype none
module fea_top #(
    parameter logic [7:0] REV_CODE = 8'h5a,  // Arbitrary revision value
    parameter logic [7:0] DEV_CODE = 8'h3c   // Arbitrary device_code value
) (
    input  wire logic            ref_clk_in,             // Block clock, 250 MHz
    input  wire logic            nrst_in,                // Async reset, active low
    input  wire fea_pkg::fea_req_t req_in,               // Register request
    input  wire fea_pkg::fea_evt_t evt_in,               // Slot event pulses
    input  wire logic [7:0]      fifo_bytes_in,          // FIFO bytes available
    input  wire logic            fifo_access_enable_in,  // FIFO access enable
    output var  logic [15:0]     rdata_out,              // Read data
    output var  logic            rvalid_out,             // Read data valid
    output var  logic            fifo_clear_out,         // FIFO clear pulse
    output var  logic            alert_pin_out,          // Alert pin level
    output var  logic            alert_pin_oe_out        // Alert pin driven
);
    import fea_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [8:0]  mask_r;
    logic [8:0]  mask_nxt;
    logic [2:0]  cfg_r;
    logic [2:0]  cfg_nxt;
    logic [5:0]  thr_r;
    logic [5:0]  thr_nxt;
    logic        rsv7_r;
    logic        rsv7_nxt;
    logic [4:0]  rsv_lo_r;
    logic [4:0]  rsv_lo_nxt;
    logic        level_r;
    logic        level_nxt;
    logic        clear_r;
    logic        clear_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic        stat_wr;
    logic        clr_a;
    logic        clr_b;
    logic        flag_a;
    logic        flag_b;
    logic        asserted;
    logic [15:0] status_word;

    // ************************************************************
    // Sticky slot event flags
    // ************************************************************

    // Write-one clears, written zero leaves flag alone
    assign stat_wr = fea_wr_hit(req_in, ADDR_STATUS);
    assign clr_a   = stat_wr & req_in.wdata[STAT_A_BIT];
    assign clr_b   = stat_wr & req_in.wdata[STAT_B_BIT];

    fea_flag u_flag_a (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .set_in     (evt_in.slot_a),
        .clr_in     (clr_a),
        .flag_out   (flag_a)
    );

    fea_flag u_flag_b (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .set_in     (evt_in.slot_b),
        .clr_in     (clr_b),
        .flag_out   (flag_b)
    );

    // ************************************************************
    // Writable settings
    // ************************************************************

    // Next values of mask, pin settings and threshold
    always_comb begin
        mask_nxt = mask_r;
        cfg_nxt  = cfg_r;
        thr_nxt  = thr_r;
        if (fea_wr_hit(req_in, ADDR_MASK)) begin
            mask_nxt = req_in.wdata[MASK_W-1:0];
        end
        if (fea_wr_hit(req_in, ADDR_CFG)) begin
            cfg_nxt = req_in.wdata[CFG_W-1:0];
        end
        if (fea_wr_hit(req_in, ADDR_THRESH)) begin
            thr_nxt = req_in.wdata[THR_LSB+THR_W-1:THR_LSB];
        end
    end

    // Settings registers; slot masks come up set
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_r <= MASK_RESET;
            cfg_r  <= CFG_RESET;
            thr_r  <= THR_RESET;
        end else begin
            mask_r <= mask_nxt;
            cfg_r  <= cfg_nxt;
            thr_r  <= thr_nxt;
        end
    end

    // ************************************************************
    // Reserved status bits
    // ************************************************************

    // Bit 7 clears on a one, bits 4:0 only on all ones
    always_comb begin
        rsv7_nxt   = rsv7_r;
        rsv_lo_nxt = rsv_lo_r;
        if (stat_wr && req_in.wdata[STAT_RSV7_BIT]) begin
            rsv7_nxt = 1'b0;
        end
        if (stat_wr && (req_in.wdata[STAT_RSV_W-1:0] == STAT_RSV_ALL)) begin
            rsv_lo_nxt = 5'h00;
        end
    end

    // Reserved bit registers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rsv7_r   <= 1'b0;
            rsv_lo_r <= 5'h00;
        end else begin
            rsv7_r   <= rsv7_nxt;
            rsv_lo_r <= rsv_lo_nxt;
        end
    end

    // ************************************************************
    // FIFO level event and clear
    // ************************************************************

    // Level follows the word count, no host clear needed
    always_comb begin
        level_nxt = fea_words(fifo_bytes_in) > {1'b0, thr_r};
        clear_nxt = stat_wr & fifo_access_enable_in
                    & req_in.wdata[STAT_CLR_BIT];
    end

    // Level and clear pulse registers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_r <= 1'b0;
            clear_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
            clear_r <= clear_nxt;
        end
    end

    assign fifo_clear_out = clear_r;

    // ************************************************************
    // Alert pin
    // ************************************************************

    // Any unmasked source asserts the alert
    assign asserted = (flag_a  & ~mask_r[MASK_A_BIT])
                    | (flag_b  & ~mask_r[MASK_B_BIT])
                    | (level_r & ~mask_r[MASK_FIFO_BIT]);

    fea_pin u_pin (
        .ref_clk_in  (ref_clk_in),
        .nrst_in     (nrst_in),
        .asserted_in (asserted),
        .enable_in   (cfg_r[CFG_EN_BIT]),
        .drive_in    (cfg_r[CFG_DRV_BIT]),
        .polarity_in (cfg_r[CFG_POL_BIT]),
        .pin_out     (alert_pin_out),
        .pin_oe_out  (alert_pin_oe_out)
    );

    // ************************************************************
    // Read path
    // ************************************************************

    // Status word with fill count on top
    assign status_word = {fifo_bytes_in, rsv7_r, flag_b, flag_a, rsv_lo_r};

    // Read mux, unmapped offsets read zero
    always_comb begin
        rvalid_nxt = req_in.rd;
        rdata_nxt  = 16'h0000;
        if (req_in.rd) begin
            case (req_in.addr)
                ADDR_STATUS: begin
                    rdata_nxt = status_word;
                end
                ADDR_MASK: begin
                    rdata_nxt = {7'h00, mask_r};
                end
                ADDR_CFG: begin
                    rdata_nxt = {13'h0000, cfg_r};
                end
                ADDR_THRESH: begin
                    rdata_nxt = {2'h0, thr_r, 8'h00};
                end
                ADDR_IDENT: begin
                    rdata_nxt = {REV_CODE, DEV_CODE};
                end
                default: begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    // Read data registers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign rdata_out  = rdata_r;
    assign rvalid_out = rvalid_r;

    // ************************************************************
    // Assertions
    // ************************************************************

    property p_fill_read;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.rd && req_in.addr == ADDR_STATUS)
        |=> rvalid_out && (rdata_out[15:8] == $past(fifo_bytes_in));
    endproperty
    a_fill_read: assert property (p_fill_read)
        else $error("fill count not read back");

    property p_level_units;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        ##1 (level_r == ($past(fifo_bytes_in) > {1'b0, $past(thr_r), 1'b1}));
    endproperty
    a_level_units: assert property (p_level_units)
        else $error("level compare not in words");

    property p_fifo_clear;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (stat_wr && req_in.wdata[STAT_CLR_BIT])
        |=> (fifo_clear_out == $past(fifo_access_enable_in)) ##1 (!fifo_clear_out || $past(stat_wr));
    endproperty
    a_fifo_clear: assert property (p_fifo_clear)
        else $error("fifo clear pulse wrong");

    property p_flag_b_clear;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clr_b && !evt_in.slot_b) |=> !flag_b;
    endproperty
    a_flag_b_clear: assert property (p_flag_b_clear)
        else $error("slot b flag not cleared");

    property p_flag_b_hold;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (flag_b && !clr_b) |=> flag_b;
    endproperty
    a_flag_b_hold: assert property (p_flag_b_hold)
        else $error("slot b flag lost");

    property p_flag_a_set;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        evt_in.slot_a |=> flag_a;
    endproperty
    a_flag_a_set: assert property (p_flag_a_set)
        else $error("slot a event lost");

    property p_masked_b;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (flag_b && mask_r[MASK_B_BIT] && !(flag_a && !mask_r[MASK_A_BIT])
         && !(level_r && !mask_r[MASK_FIFO_BIT])
         && cfg_r[CFG_EN_BIT] && cfg_r[CFG_DRV_BIT])
        |=> !alert_pin_oe_out;
    endproperty
    a_masked_b: assert property (p_masked_b)
        else $error("masked slot b event drove alert");

    property p_level_drop;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (level_r && !(fea_words(fifo_bytes_in) > {1'b0, thr_r})) |=> !level_r;
    endproperty
    a_level_drop: assert property (p_level_drop)
        else $error("level event did not withdraw");

    property p_pin_float;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !cfg_r[CFG_EN_BIT] |=> !alert_pin_oe_out;
    endproperty
    a_pin_float: assert property (p_pin_float)
        else $error("disabled pin was driven");

    property p_pin_push;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (cfg_r[CFG_EN_BIT] && !cfg_r[CFG_DRV_BIT])
        |=> alert_pin_oe_out && (alert_pin_out == ($past(asserted) ^ $past(cfg_r[CFG_POL_BIT])));
    endproperty
    a_pin_push: assert property (p_pin_push)
        else $error("push-pull pin level wrong");

    property p_flag_b_set;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        evt_in.slot_b |=> flag_b;
    endproperty
    a_flag_b_set: assert property (p_flag_b_set)
        else $error("slot b event lost");

    property p_flag_a_clear;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clr_a && !evt_in.slot_a) |=> !flag_a;
    endproperty
    a_flag_a_clear: assert property (p_flag_a_clear)
        else $error("slot a flag not cleared");

    property p_level_rise;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (fifo_bytes_in > {1'b0, thr_r, 1'b1}) |=> level_r;
    endproperty
    a_level_rise: assert property (p_level_rise)
        else $error("level event not raised");

    property p_level_alert;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (level_r && !mask_r[MASK_FIFO_BIT] && cfg_r[CFG_EN_BIT])
        |=> alert_pin_oe_out && (alert_pin_out != $past(cfg_r[CFG_POL_BIT]));
    endproperty
    a_level_alert: assert property (p_level_alert)
        else $error("unmasked level event missed alert");

    property p_masked_a;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (flag_a && mask_r[MASK_A_BIT] && !(flag_b && !mask_r[MASK_B_BIT])
         && !(level_r && !mask_r[MASK_FIFO_BIT])
         && cfg_r[CFG_EN_BIT] && cfg_r[CFG_DRV_BIT])
        |=> !alert_pin_oe_out;
    endproperty
    a_masked_a: assert property (p_masked_a)
        else $error("masked slot a event drove alert");

    property p_pin_drain;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (cfg_r[CFG_EN_BIT] && cfg_r[CFG_DRV_BIT] && !asserted) |=> !alert_pin_oe_out;
    endproperty
    a_pin_drain: assert property (p_pin_drain)
        else $error("open-drain pin driven while idle");

endmodule : fea_top
`default_nettype wire

// >>> test/fea_host.sv
`timescale 1ns/1ns
`default_nettype none
module fea_host (
    input  wire logic              ref_clk_in,   // Block clock
    input  wire logic [15:0]       rdata_in,     // Read data
    input  wire logic              rvalid_in,    // Read data valid
    input  wire logic              pin_in,       // Alert pin level
    input  wire logic              pin_oe_in,    // Alert pin driven
    input  wire logic              pull_high_in, // Resistor pulls wire high
    output var  fea_pkg::fea_req_t req_out,      // Register request
    output var  logic              wire_out      // Resolved alert wire
);
    import fea_pkg::*;

    // Released wire settles at the resistor level
    assign wire_out = pin_oe_in ? pin_in : pull_high_in;

    initial begin
        req_out = '0;
    end

    // One write strobe, data flipped once released
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(posedge ref_clk_in);
        #1;
        req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk_in);
        #1;
        req_out = '{wr: 1'b0, rd: 1'b0, addr: addr, wdata: ~data};
    endtask : write_reg

    // One read strobe, answer taken in the cycle after
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        @(posedge ref_clk_in);
        #1;
        req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        @(posedge ref_clk_in);
        #1;
        req_out = '0;
        ok = rvalid_in;
        data = rdata_in;
    endtask : read_reg

    // Clears reserved bit 7 and reserved bits 4:0
    task automatic clear_reserved();
        write_reg(ADDR_STATUS, 16'h009f);
    endtask : clear_reserved
endmodule : fea_host
`default_nettype wire

// >>> test/fea_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fea_top_bench;
    import fea_pkg::*;
    localparam logic [7:0] REV = 8'h5a; // Arbitrary value
    localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
    logic     ref_clk_in = 1'b0;
    logic     nrst_in = 1'b0;
    fea_req_t req;
    fea_evt_t evt = '0;
    logic [7:0]  bytes = 8'h00;
    logic        fifo_en = 1'b0;
    logic [15:0] rdata;
    logic        rvalid, fifo_clear, pin, pin_oe, pull_high = 1'b0, wire_lvl;
    logic [15:0] d;
    logic        ok;
    logic [5:0]  thr;
    int          mismatches = 0, comparisons = 0, seed = 17175;

    // ************************************************************
    // Clock, design and host
    // ************************************************************
    always #2 ref_clk_in = ~ref_clk_in;
    fea_top #(.REV_CODE(REV), .DEV_CODE(DEV)) DUT (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .req_in(req), .evt_in(evt),
        .fifo_bytes_in(bytes), .fifo_access_enable_in(fifo_en), .rdata_out(rdata),
        .rvalid_out(rvalid), .fifo_clear_out(fifo_clear), .alert_pin_out(pin),
        .alert_pin_oe_out(pin_oe));
    fea_host host (
        .ref_clk_in(ref_clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .pin_in(pin),
        .pin_oe_in(pin_oe), .pull_high_in(pull_high), .req_out(req), .wire_out(wire_lvl));

    // ************************************************************
    // Expectations and checks
    // ************************************************************
    // Level event: bytes halved to words, strictly above threshold
    function automatic logic level_hit(input logic [7:0] b, input logic [5:0] t);
        return b[7:1] > {1'b0, t};
    endfunction : level_hit
    // Expected {driven, wire level}; released wire rests at polarity level
    function automatic logic [1:0] pin_exp(input logic [2:0] cfg, input logic a);
        return {cfg[2] & (~cfg[1] | a), (cfg[2] & a) ^ cfg[0]};
    endfunction : pin_exp
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd_check(input logic [7:0] addr, input logic [15:0] exp);
        host.read_reg(addr, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, exp);
    endtask : rd_check
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : idle
    task automatic pulse(input fea_evt_t e);
        idle(1);
        evt = e;
        idle(1);
        evt = '0;
    endtask : pulse
    task automatic set_cfg(input logic [2:0] cfg);
        host.write_reg(ADDR_CFG, {13'h0000, cfg});
        pull_high = cfg[0];
        idle(3);
    endtask : set_cfg
    task automatic pin_check(input logic [2:0] cfg, input logic a);
        check({14'h0000, pin_oe, wire_lvl}, {14'h0000, pin_exp(cfg, a)});
    endtask : pin_check
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // ************************************************************
    // Watchdog
    // ************************************************************
    initial begin
        #(4 * 20000);
        mismatches++;
        stop_test();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        idle(20);
        nrst_in = 1'b1;
        bytes = 8'ha7;
        rd_check(ADDR_MASK, 16'h00ff);
        rd_check(ADDR_CFG, 16'h0000);
        rd_check(ADDR_THRESH, 16'h0000);
        rd_check(ADDR_IDENT, {REV, DEV});
        rd_check(ADDR_STATUS, 16'ha700);
        rd_check(8'h03, 16'h0000);
        host.write_reg(ADDR_IDENT, 16'hffff);
        rd_check(ADDR_IDENT, {REV, DEV});
        // Sticky flags: set, survive a zero write, clear on a one
        for (int i = 0; i < 2; i++) begin
            pulse(i ? 2'b10 : 2'b01);
            rd_check(ADDR_STATUS, {bytes, 8'h20 << i});
            host.write_reg(ADDR_STATUS, 16'h0000);
            rd_check(ADDR_STATUS, {bytes, 8'h20 << i});
            host.write_reg(ADDR_STATUS, 16'h0020 << i);
            rd_check(ADDR_STATUS, {bytes, 8'h00});
        end
        host.clear_reserved();
        rd_check(ADDR_STATUS, {bytes, 8'h00});
        // FIFO clear pulse only with access enabled
        for (int e = 0; e < 2; e++) begin
            fifo_en = e[0];
            host.write_reg(ADDR_STATUS, 16'h8000);
            check({15'h0000, fifo_clear}, e[15:0]);
            idle(1);
            check({15'h0000, fifo_clear}, 16'h0000);
        end
        // Every pin configuration, idle then asserted by slot A
        bytes = 8'h00;
        host.write_reg(ADDR_MASK, 16'h00df);
        for (int c = 0; c < 8; c++) begin
            set_cfg(c[2:0]);
            pin_check(c[2:0], 1'b0);
            pulse(2'b01);
            idle(2);
            pin_check(c[2:0], 1'b1);
            host.write_reg(ADDR_STATUS, 16'h0020);
            idle(2);
            pin_check(c[2:0], 1'b0);
        end
        // Masked slots set flags but keep the pin quiet
        host.write_reg(ADDR_MASK, 16'h01ff);
        pulse(2'b11);
        idle(2);
        pin_check(3'h7, 1'b0);
        rd_check(ADDR_STATUS, 16'h0060);
        host.write_reg(ADDR_MASK, 16'h01bf);
        idle(2);
        pin_check(3'h7, 1'b1);
        host.write_reg(ADDR_STATUS, 16'h0060);
        host.write_reg(ADDR_MASK, 16'h00ff);
        set_cfg(3'h4);
        // FIFO level against threshold, boundaries first
        for (int i = 0; i < 40; i++) begin
            thr = 6'($random(seed));
            host.write_reg(ADDR_THRESH, {2'b00, thr, 8'h00});
            bytes = (i < 2) ? ({1'b0, thr, 1'b1} + 8'(i)) : 8'($random(seed));
            idle(3);
            pin_check(3'h4, level_hit(bytes, thr));
            rd_check(ADDR_STATUS, {bytes, 8'h00});
        end
        thr = 6'h00;
        host.write_reg(ADDR_THRESH, 16'h0000);
        bytes = 8'h10;
        host.write_reg(ADDR_MASK, 16'h01ff);
        idle(3);
        pin_check(3'h4, 1'b0);
        stop_test();
    end
endmodule : fea_top_bench
`default_nettype wire
